// ### cocw_host_model.sv
// Host controller model driving the decoded register command port.
// Assumes the block samples commands on the rising clock edge.
`timescale 1ns/10ps

module cocw_host_model (
  input  wire logic        clock,
  output logic      [7:0]  reg_addr,
  output logic             reg_write,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata
);
  // Idle command port from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 16'h0000;
  end

  // One write strobe per edge; data inverted after, so stale data never looks valid
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~data;
  endtask : write_reg

  // Read data is registered one edge after the address is taken
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
    @(posedge clock);
    reg_addr <= addr;
    repeat (2) @(posedge clock);
    #1 data = reg_rdata;
  endtask : read_reg
endmodule : cocw_host_model

// ### cocw_pkg.sv
// Types shared by the charger option control and watchdog block.
// Assumes the constants header is compiled alongside.
package cocw_pkg;

  typedef logic [15:0] cocw_word_t;

  // Watchdog states
  typedef enum logic [1:0] {
    COCW_WD_OFF,
    COCW_WD_RUN,
    COCW_WD_EXPIRED
  } cocw_wd_e;

endpackage : cocw_pkg

// ### cocw_regs.svh
// Offsets, field positions, reset values and timing constants for the
// charger option control and watchdog block. Definitions only.
`ifndef COCW_REGS_SVH
`define COCW_REGS_SVH

// Register command codes
`define COCW_ADDR_OPT0     8'h12
`define COCW_ADDR_CURR     8'h14
`define COCW_ADDR_VOLT     8'h15
`define COCW_ADDR_OPT1     8'h30

// Option 0 field positions
`define COCW_BIT_LWPWR     15
`define COCW_BIT_WDT_HI    14
`define COCW_BIT_WDT_LO    13
`define COCW_BIT_AUTO_OFF  12
`define COCW_BIT_OTG_OK    11
`define COCW_BIT_OOA       10
`define COCW_BIT_IREG      1
`define COCW_BIT_INHIBIT   0

// Option 1 field positions
`define COCW_BIT_DCHG_MON  15
`define COCW_BIT_CMP_LP_HI 14
`define COCW_BIT_CMP_LP_LO 13
`define COCW_BIT_PSYS_MON  12

// Reset values
`define COCW_RST_OPT0      16'hE20E
`define COCW_RST_OPT1      16'h0211
`define COCW_RST_CURR      16'h0000
`define COCW_RST_VOLT      16'h1060

// Settable bits of the setpoint registers
`define COCW_MASK_CURR     16'h1FC0
`define COCW_MASK_VOLT     16'h7FF0

// Watchdog timing
`define COCW_CLK_HZ        50000000
`define COCW_TICK_MS       1
`define COCW_MS_PER_SEC    1000
`define COCW_WDT_T1_SEC    5
`define COCW_WDT_T2_SEC    88
`define COCW_WDT_T3_SEC    175

`endif

// ### cocw_top.sv
// Charger option control and watchdog: option registers, setpoints,
// low power gating, watchdog, input regulation auto-off, status outputs.
// Assumes a command layer that hands over decoded register writes,
// and inputs synchronous to clock.
//
// Functional notes
// RQ1 - Low power on battery gates monitors, ADC
// RQ2 - Performance mode follows own register settings
// RQ3 - Option1 bit 14/13 keeps comparator alive
// RQ4 - Timeout code selects off, 5, 88, 175 s
// RQ5 - Expiry forces charge current register to zero
// RQ6 - Restart on setpoint or timeout field write
// RQ7 - Auto-off clears regulation enable on pin fall
// RQ8 - Host may rewrite regulation enable to one
// RQ9 - Auto-off disabled leaves regulation enable alone
// RQ10 - Optional OTG report on charge ok output
// RQ11 - Out-of-audio bit floors burst frequency 25 kHz
// RQ12 - Reset values of the upper option fields
// RQ13 - Regulation enable host writable, hardware clearable
// RQ14 - Charge current is 7 bits, 64 mA step
// RQ15 - Setpoint writes restart running watchdog count
`timescale 1ns/10ps
`include "cocw_regs.svh"

module cocw_top #(
  parameter int TICK_CYCLES = `COCW_CLK_HZ / 1000 * `COCW_TICK_MS
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_write,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        battery_only,
  input  wire logic        battery_present_pin,
  input  wire logic        otg_mode,
  input  wire logic        adapter_ok,
  input  wire logic        prochot_request,
  input  wire logic        comparator_request,
  input  wire logic        adc_request,
  output logic             prochot_enable,
  output logic             discharge_monitor_enable,
  output logic             power_monitor_enable,
  output logic             comparator_enable,
  output logic             adc_available,
  output logic             charge_ok_output,
  output logic             burst_floor_enable,
  output logic             input_regulation_enable,
  output logic             charge_enable,
  output logic      [6:0]  charge_current_setting,
  output logic      [10:0] charge_voltage_setting,
  output logic             watchdog_expired
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);
  localparam int MS_W   = 18;

  cocw_pkg::cocw_word_t opt0;
  cocw_pkg::cocw_word_t opt1;
  cocw_pkg::cocw_word_t curr;
  cocw_pkg::cocw_word_t volt;
  cocw_pkg::cocw_wd_e   wd_state;
  cocw_pkg::cocw_wd_e   next_wd_state;
  logic [TICK_W-1:0]    tick_count;
  logic [MS_W-1:0]      wd_ms;
  logic                 pin_q;

  // Timeout code to milliseconds; code 00 yields zero, never used
  function automatic logic [MS_W-1:0] limit_ms(input logic [1:0] sel);
    case (sel)
      2'h1:    limit_ms = MS_W'(`COCW_WDT_T1_SEC * `COCW_MS_PER_SEC);
      2'h2:    limit_ms = MS_W'(`COCW_WDT_T2_SEC * `COCW_MS_PER_SEC);
      2'h3:    limit_ms = MS_W'(`COCW_WDT_T3_SEC * `COCW_MS_PER_SEC);
      default: limit_ms = '0;
    endcase
  endfunction : limit_ms

  // Write decode
  wire       wr_opt0 = reg_write && (reg_addr == `COCW_ADDR_OPT0);
  wire       wr_curr = reg_write && (reg_addr == `COCW_ADDR_CURR);
  wire       wr_volt = reg_write && (reg_addr == `COCW_ADDR_VOLT);
  wire       wr_opt1 = reg_write && (reg_addr == `COCW_ADDR_OPT1);

  // Field views
  wire       low_power_enable          = opt0[`COCW_BIT_LWPWR];
  wire [1:0] watchdog_timeout_select   = opt0[`COCW_BIT_WDT_HI:`COCW_BIT_WDT_LO];
  wire       input_regulation_auto_off = opt0[`COCW_BIT_AUTO_OFF];
  wire       otg_reports_charge_ok     = opt0[`COCW_BIT_OTG_OK];
  wire       out_of_audio_enable       = opt0[`COCW_BIT_OOA];
  wire       ireg     = opt0[`COCW_BIT_IREG];
  wire       inhibit  = opt0[`COCW_BIT_INHIBIT];
  wire       cmp_keep = opt1[`COCW_BIT_CMP_LP_HI] | opt1[`COCW_BIT_CMP_LP_LO];

  // Pin fall seen against the previous sample; pin is already synchronous
  wire       pin_fall  = pin_q && !battery_present_pin;
  wire       auto_kill = input_regulation_auto_off && pin_fall;

  // Watchdog timing
  wire       tick    = (tick_count == TICK_W'(TICK_CYCLES - 1));
  wire       wd_last = tick && (wd_ms == limit_ms(watchdog_timeout_select) - MS_W'(1));

  // Any setpoint write, or any write carrying the timeout field, restarts
  wire       wd_kick = wr_curr || wr_volt || wr_opt0;
  wire       wd_fire = (wd_state == cocw_pkg::COCW_WD_RUN) && wd_last && !wd_kick;

  // Option 0 next value; hardware clear beats a same-cycle host set
  wire [15:0] opt0_src   = wr_opt0 ? reg_wdata : opt0;
  wire [15:0] next_opt0  = auto_kill ? (opt0_src & ~(16'h0001 << `COCW_BIT_IREG)) : opt0_src;

  // Charge current next value; expiry parks the setpoint at zero
  wire [15:0] next_curr = wd_fire ? 16'h0000 :
                          wr_curr ? (reg_wdata & `COCW_MASK_CURR) : curr;

  // Low power gating only applies on battery alone
  wire       lp_active  = low_power_enable && battery_only;

  wire       next_prochot = !lp_active && prochot_request;
  wire       next_dchg    = !lp_active && opt1[`COCW_BIT_DCHG_MON];
  wire       next_psys    = !lp_active && opt1[`COCW_BIT_PSYS_MON];
  wire       next_cmp     = lp_active ? cmp_keep : comparator_request;
  wire       next_adc     = !lp_active && adc_request;

  // Status outputs
  wire       next_chg_ok = adapter_ok || (otg_reports_charge_ok && otg_mode);

  // Charging resumes only with valid, nonzero setpoints
  wire       next_chg_en = (wd_state != cocw_pkg::COCW_WD_EXPIRED) && !inhibit &&
                           (curr != 16'h0000) && (volt != 16'h0000);

  // Read selection; unmapped codes read as zero
  wire [15:0] next_rdata = (reg_addr == `COCW_ADDR_OPT0) ? opt0 :
                           (reg_addr == `COCW_ADDR_CURR) ? curr :
                           (reg_addr == `COCW_ADDR_VOLT) ? volt :
                           (reg_addr == `COCW_ADDR_OPT1) ? opt1 : 16'h0000;

  // Watchdog state decision
  always_comb begin
    next_wd_state = wd_state;
    case (wd_state)
      cocw_pkg::COCW_WD_OFF: begin
        if (watchdog_timeout_select != 2'h0) begin
          next_wd_state = cocw_pkg::COCW_WD_RUN;
        end
      end
      cocw_pkg::COCW_WD_RUN: begin
        if (watchdog_timeout_select == 2'h0) begin
          next_wd_state = cocw_pkg::COCW_WD_OFF;
        end else if (wd_fire) begin
          next_wd_state = cocw_pkg::COCW_WD_EXPIRED; // RQ5
        end
      end
      cocw_pkg::COCW_WD_EXPIRED: begin
        if (wd_kick) begin
          next_wd_state = cocw_pkg::COCW_WD_OFF; // RQ6
        end
      end
      default: next_wd_state = cocw_pkg::COCW_WD_OFF;
    endcase
  end

  // Option registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      opt0 <= `COCW_RST_OPT0; // RQ12
      opt1 <= `COCW_RST_OPT1;
    end else begin
      opt0 <= next_opt0; // RQ7 RQ8 RQ9 RQ13
      opt1 <= wr_opt1 ? reg_wdata : opt1;
    end
  end

  // Setpoint registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      curr <= `COCW_RST_CURR;
      volt <= `COCW_RST_VOLT;
    end else begin
      curr <= next_curr; // RQ5 RQ14
      volt <= wr_volt ? (reg_wdata & `COCW_MASK_VOLT) : volt;
    end
  end

  // Watchdog counters; restart zeroes both so a kick gives a full period
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wd_state   <= cocw_pkg::COCW_WD_OFF;
      tick_count <= '0;
      wd_ms      <= '0;
    end else begin
      wd_state <= next_wd_state;
      if (wd_kick || wd_state != cocw_pkg::COCW_WD_RUN) begin
        tick_count <= '0; // RQ15
        wd_ms      <= '0;
      end else if (tick) begin
        tick_count <= '0; // RQ4
        wd_ms      <= wd_ms + MS_W'(1);
      end else begin
        tick_count <= tick_count + TICK_W'(1);
      end
    end
  end

  // Pin history for fall detection
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_q <= 1'b1;
    end else begin
      pin_q <= battery_present_pin;
    end
  end

  // Gated enables
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prochot_enable           <= 1'b0;
      discharge_monitor_enable <= 1'b0;
      power_monitor_enable     <= 1'b0;
      comparator_enable        <= 1'b0;
      adc_available            <= 1'b0;
    end else begin
      prochot_enable           <= next_prochot; // RQ1 RQ2
      discharge_monitor_enable <= next_dchg;
      power_monitor_enable     <= next_psys;
      comparator_enable        <= next_cmp; // RQ3
      adc_available            <= next_adc;
    end
  end

  // Status and setpoint outputs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      charge_ok_output        <= 1'b0;
      burst_floor_enable      <= 1'b0;
      input_regulation_enable <= 1'b0;
      charge_enable           <= 1'b0;
      charge_current_setting  <= 7'h00;
      charge_voltage_setting  <= 11'h000;
      watchdog_expired        <= 1'b0;
      reg_rdata               <= 16'h0000;
    end else begin
      charge_ok_output        <= next_chg_ok; // RQ10
      burst_floor_enable      <= out_of_audio_enable; // RQ11
      input_regulation_enable <= ireg;
      charge_enable           <= next_chg_en; // RQ6
      charge_current_setting  <= curr[12:6];
      charge_voltage_setting  <= volt[14:4];
      watchdog_expired        <= (wd_state == cocw_pkg::COCW_WD_EXPIRED);
      reg_rdata               <= next_rdata;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_lp_gates_all: assert property ( // RQ1
    lp_active |=> !prochot_enable && !discharge_monitor_enable && !power_monitor_enable && !adc_available
  ) else $error("low power mode left a monitor or the ADC on");

  a_perf_follows: assert property ( // RQ2
    (battery_only && !low_power_enable) |=> (prochot_enable == $past(prochot_request)) &&
                                 (comparator_enable == $past(comparator_request))
  ) else $error("performance mode did not follow settings");

  a_cmp_keep_alive: assert property ( // RQ3
    (lp_active && cmp_keep) |=> comparator_enable
  ) else $error("comparator not kept on in low power mode");

  a_wd_off_code: assert property ( // RQ4
    (watchdog_timeout_select == 2'h0 && wd_state != cocw_pkg::COCW_WD_EXPIRED) |=>
      wd_state != cocw_pkg::COCW_WD_EXPIRED
  ) else $error("watchdog expired while disabled");

  a_wd_expiry_zero: assert property ( // RQ5
    $rose(wd_state == cocw_pkg::COCW_WD_EXPIRED) |-> (curr == 16'h0000) ##1 watchdog_expired && !charge_enable
  ) else $error("expiry did not suspend charging");

  a_wd_restart: assert property ( // RQ6
    (wd_state == cocw_pkg::COCW_WD_EXPIRED && wd_kick) |=> wd_state == cocw_pkg::COCW_WD_OFF ##1
      (watchdog_timeout_select == 2'h0 || wd_state == cocw_pkg::COCW_WD_RUN)
  ) else $error("watchdog did not restart after kick");

  a_auto_clear: assert property ( // RQ7
    auto_kill |=> !ireg ##1 !input_regulation_enable
  ) else $error("auto-off did not clear regulation enable");

  a_host_reenable: assert property ( // RQ8
    (wr_opt0 && reg_wdata[`COCW_BIT_IREG] && !auto_kill) |=> ireg
  ) else $error("host write of regulation enable lost");

  a_auto_keep: assert property ( // RQ9
    (!input_regulation_auto_off && pin_fall && !wr_opt0) |=> ireg == $past(ireg)
  ) else $error("regulation enable changed with auto-off disabled");

  a_otg_report: assert property ( // RQ10
    (!adapter_ok && otg_mode) |=> charge_ok_output == $past(otg_reports_charge_ok)
  ) else $error("OTG report on charge ok wrong");

  a_ooa_floor: assert property ( // RQ11
    $changed(out_of_audio_enable) |=> burst_floor_enable == $past(out_of_audio_enable)
  ) else $error("burst floor does not track out-of-audio bit");

  a_reset_fields: assert property ( // RQ12
    $rose(resetn) |-> opt0[15:10] == 6'h38
  ) else $error("upper option fields wrong after reset");

  a_curr_width: assert property ( // RQ14
    (curr & ~`COCW_MASK_CURR) == 16'h0000
  ) else $error("charge current holds bits outside its field");

  a_wd_refresh: assert property ( // RQ15
    (wd_state == cocw_pkg::COCW_WD_RUN && (wr_curr || wr_volt)) |=> wd_ms == '0 && tick_count == '0
  ) else $error("setpoint write did not restart watchdog count");

endmodule : cocw_top

// ### cocw_top_tb.sv
// Self-checking bench for the option control and watchdog block.
// Assumes the host model drives the command port; tick shortened to 4 cycles.
`timescale 1ns/10ps

module cocw_top_tb;
  typedef struct packed {
    logic [15:0] opt0;
    logic [15:0] opt1;
    logic [5:0]  ins;
    logic [6:0]  exp;
  } cocw_row_s;

  logic        clock;
  logic        resetn;
  logic [7:0]  reg_addr;
  logic        reg_write;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        battery_only, battery_present_pin, otg_mode, adapter_ok;
  logic        prochot_request, comparator_request, adc_request;
  logic        prochot_enable, discharge_monitor_enable, power_monitor_enable;
  logic        comparator_enable, adc_available, charge_ok_output, burst_floor_enable;
  logic        input_regulation_enable, charge_enable, watchdog_expired;
  logic [6:0]  charge_current_setting;
  logic [10:0] charge_voltage_setting;
  logic [15:0] rd;
  logic [6:0]  obs;
  int          num_errors = 0;
  int          n_checks = 0;

  // Rows: option words, {batt_only,otg,adapter,prochot,cmp,adc}, expected status
  cocw_row_s rows [8] = '{
    '{16'hE20E, 16'h9000, 6'h27, 7'h00}, '{16'hE20E, 16'hD000, 6'h27, 7'h08},
    '{16'hE20E, 16'hB000, 6'h27, 7'h08}, '{16'h420E, 16'h9000, 6'h27, 7'h7C},
    '{16'hE20E, 16'h9000, 6'h07, 7'h7C}, '{16'h6A0E, 16'h0000, 6'h10, 7'h02},
    '{16'h620E, 16'h0000, 6'h10, 7'h00}, '{16'h660E, 16'h0000, 6'h08, 7'h03}};

  assign obs = {prochot_enable, discharge_monitor_enable, power_monitor_enable,
                comparator_enable, adc_available, charge_ok_output, burst_floor_enable};

  cocw_top #(.TICK_CYCLES(4)) cocw_top_i (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .battery_only(battery_only),
    .battery_present_pin(battery_present_pin), .otg_mode(otg_mode), .adapter_ok(adapter_ok),
    .prochot_request(prochot_request), .comparator_request(comparator_request),
    .adc_request(adc_request), .prochot_enable(prochot_enable),
    .discharge_monitor_enable(discharge_monitor_enable), .power_monitor_enable(power_monitor_enable),
    .comparator_enable(comparator_enable), .adc_available(adc_available),
    .charge_ok_output(charge_ok_output), .burst_floor_enable(burst_floor_enable),
    .input_regulation_enable(input_regulation_enable), .charge_enable(charge_enable),
    .charge_current_setting(charge_current_setting), .charge_voltage_setting(charge_voltage_setting),
    .watchdog_expired(watchdog_expired));

  cocw_host_model cocw_host_model_i (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Settle past the edge so registered outputs are read after they land
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : cyc

  task automatic end_sim;
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Hang guard sized above the ~60k cycles the sequence needs
  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    {battery_only, otg_mode, adapter_ok, prochot_request, comparator_request, adc_request} = 6'h00;
    battery_present_pin = 1'b1;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    cyc(2);
    check("reg_enable_reset", 16'h0001, {15'h0, input_regulation_enable});
    cocw_host_model_i.read_reg(8'h12, rd);
    check("opt0_reset", 16'hE20E, rd);
    foreach (rows[i]) begin
      cocw_host_model_i.write_reg(8'h12, rows[i].opt0);
      cocw_host_model_i.write_reg(8'h30, rows[i].opt1);
      @(posedge clock);
      {battery_only, otg_mode, adapter_ok, prochot_request, comparator_request, adc_request} <= rows[i].ins;
      cyc(3);
      check("status_row", {9'h0, rows[i].exp}, {9'h0, obs});
      cocw_host_model_i.read_reg(8'h12, rd);
      check("opt0_readback", rows[i].opt0, rd);
    end
    // Auto-off on pin fall, host re-enable, then auto-off disabled
    cocw_host_model_i.write_reg(8'h12, 16'hF20E);
    @(posedge clock);
    battery_present_pin <= 1'b0;
    cyc(3);
    check("reg_enable_auto_off", 16'h0000, {15'h0, input_regulation_enable});
    cocw_host_model_i.read_reg(8'h12, rd);
    check("opt0_after_auto_off", 16'hF20C, rd);
    cocw_host_model_i.write_reg(8'h12, 16'hF20E);
    cyc(2);
    check("reg_enable_rewrite", 16'h0001, {15'h0, input_regulation_enable});
    @(posedge clock);
    battery_present_pin <= 1'b1;
    cocw_host_model_i.write_reg(8'h12, 16'hE20E);
    @(posedge clock);
    battery_present_pin <= 1'b0;
    cyc(3);
    check("reg_enable_kept", 16'h0001, {15'h0, input_regulation_enable});
    // Watchdog at 5 s code: 5000 ticks of 4 cycles
    cocw_host_model_i.write_reg(8'h12, 16'hA20E);
    // Bits outside both setpoint fields are written and must be dropped
    cocw_host_model_i.write_reg(8'h15, 16'h20FF);
    cocw_host_model_i.write_reg(8'h14, 16'hE43F);
    cyc(2);
    check("current_setting", 16'h0010, {9'h0, charge_current_setting});
    check("voltage_setting", 16'h020F, {5'h0, charge_voltage_setting});
    check("charge_on", 16'h0001, {15'h0, charge_enable});
    cyc(15000);
    cocw_host_model_i.write_reg(8'h14, 16'h0400);
    cyc(19990);
    check("wd_not_yet", 16'h0000, {15'h0, watchdog_expired});
    cyc(20);
    check("wd_expired", 16'h0001, {15'h0, watchdog_expired});
    check("charge_suspended", 16'h0000, {15'h0, charge_enable});
    cocw_host_model_i.read_reg(8'h14, rd);
    check("current_zeroed", 16'h0000, rd);
    cocw_host_model_i.write_reg(8'h14, 16'h0400);
    cyc(3);
    check("wd_restarted", 16'h0000, {15'h0, watchdog_expired});
    check("charge_resumed", 16'h0001, {15'h0, charge_enable});
    cocw_host_model_i.write_reg(8'h12, 16'h820E);
    cyc(25000);
    check("wd_disabled", 16'h0000, {15'h0, watchdog_expired});
    cocw_host_model_i.write_reg(8'h12, 16'h820F);
    cyc(2);
    check("charge_inhibited", 16'h0000, {15'h0, charge_enable});
    cocw_host_model_i.write_reg(8'h40, 16'hFFFF);
    cocw_host_model_i.read_reg(8'h40, rd);
    check("unmapped_read", 16'h0000, rd);
    cocw_host_model_i.read_reg(8'h14, rd);
    check("curr_after_unmapped", 16'h0400, rd);
    // Mid-run reset with the pin still low; option word must return to its reset value
    @(posedge clock);
    resetn <= 1'b0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    cyc(2);
    check("charge_off_reset", 16'h0000, {15'h0, charge_enable});
    cocw_host_model_i.read_reg(8'h12, rd);
    check("opt0_mid_reset", 16'hE20E, rd);
    end_sim();
  end
endmodule : cocw_top_tb
